// ### core/cca_lqi_unit.sv
/*
 clear channel assessment and link quality unit with a classic wishbone slave.
 assumes radio status strobes come from baseband logic on mclk, and that the
 frame buffer accepts one appended byte per frame end.
*/
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module cca_lqi_unit
   import cca_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // radio baseband
   input  wire radio_s      radio,
   output logic             header_detect_disable,
   // events and frame buffer
   output logic             measurement_done_irq,
   output fb_wr_s           fb_wr
);
   typedef enum logic [1:0] {S_IDLE, S_START, S_LISTEN, S_WAIT} cca_st_e;

   cca_st_e            st_reg;
   logic [1:0]         mode_reg;
   logic [THRES_W-1:0] thres_reg;
   logic               done_reg;
   logic               idle_reg;
   logic [CNT_W-1:0]   cnt_reg;
   logic               seen_busy_reg;
   logic               ed_active_reg;
   logic               ed_used_reg;
   logic               ed_fin_reg;
   logic [CNT_W-1:0]   ed_cnt_reg;
   logic [7:0]         ed_peak_reg;
   logic [7:0]         lqi_reg;
   logic               lqi_valid;
   logic [7:0]         lqi_val;

   // bus decode
   wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr_hit    = wb_req & wb_we_i & wb_sel_i[0];
   wire        ctrl_wr   = wr_hit && wb_adr_i == CTRL_OFS;
   wire        thres_wr  = wr_hit && wb_adr_i == THRES_OFS;
   wire        req_pulse = ctrl_wr & wb_dat_i[REQ_BIT];
   wire [31:0] status_rd = {27'h0, st_reg != S_IDLE, radio.state, idle_reg, done_reg};
   wire [31:0] rd_data   = wb_adr_i == CTRL_OFS   ? {28'h0, header_detect_disable,
                                                     mode_reg, 1'b0} :
                           wb_adr_i == THRES_OFS  ? {28'h0, thres_reg} :
                           wb_adr_i == STATUS_OFS ? status_rd :
                           wb_adr_i == LQI_OFS    ? {24'h0, lqi_reg} : 32'h0;

   // channel decision per mode
   wire [7:0] thres_lvl = {3'h0, thres_reg, 1'b0};
   wire       use_ed    = radio.state == RX_BUSY && st_reg != S_LISTEN;
   wire [7:0] energy    = use_ed ? ed_peak_reg : radio.energy;
   wire       en_busy   = energy > thres_lvl;
   wire       cs_busy   = radio.carrier;
   wire       chan_busy = mode_reg == MODE_ENERGY ? en_busy :
                          mode_reg == MODE_CARR   ? cs_busy :
                          mode_reg == MODE_AND    ? en_busy & cs_busy :
                                                    en_busy | cs_busy;

   // sequencing decisions
   wire listening  = radio.state == RX_LISTEN || header_detect_disable;
   wire in_rx      = radio.state != RX_OFF;
   wire no_wait    = mode_reg == MODE_CARR || !ed_active_reg;
   wire meas_win   = cnt_reg < CNT_W'(MEAS_CYC);
   wire listen_end = st_reg == S_LISTEN && cnt_reg == CNT_W'(RESULT_CYC - 1);
   wire busy_end   = (st_reg == S_START && in_rx && !listening && no_wait) ||
                     (st_reg == S_WAIT && !ed_active_reg);
   wire void_end   = st_reg == S_START && !in_rx;
   wire finish     = listen_end | busy_end | void_end;
   wire found_busy = (st_reg == S_LISTEN ? seen_busy_reg : 1'b0) |
                     (busy_end & chan_busy);
   wire ed_start   = radio.shr & ~ed_used_reg & ~ed_active_reg;
   wire ed_last    = ed_active_reg && ed_cnt_reg == CNT_W'(MEAS_CYC - 1);

   // wishbone answer, one cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req)
            wb_dat_o <= wb_we_i ? 32'h0 : rd_data;
      end
   end

   // software controlled configuration
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg              <= MODE_RST;
         thres_reg             <= THRES_RST;
         header_detect_disable <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            mode_reg              <= wb_dat_i[MODE_LSB +: 2];
            header_detect_disable <= wb_dat_i[HDD_BIT];
         end
         if (thres_wr)
            thres_reg <= wb_dat_i[THRES_W-1:0];
      end
   end

   // assessment sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg        <= S_IDLE;
         cnt_reg       <= '0;
         seen_busy_reg <= 1'b0;
      end else if (req_pulse) begin
         st_reg        <= S_START;
         cnt_reg       <= '0;
         seen_busy_reg <= 1'b0;
      end else begin
         unique case (st_reg)
            S_IDLE: st_reg <= S_IDLE;
            S_START: begin
               if (!in_rx || busy_end)
                  st_reg <= S_IDLE;
               else if (listening)
                  st_reg <= S_LISTEN;
               else
                  st_reg <= S_WAIT;
            end
            S_LISTEN: begin
               cnt_reg <= cnt_reg + CNT_W'(1);
               if (meas_win && chan_busy)
                  seen_busy_reg <= 1'b1;
               if (listen_end)
                  st_reg <= S_IDLE;
            end
            S_WAIT: if (busy_end) st_reg <= S_IDLE;
         endcase
      end
   end

   // result flags, completion wins over a clearing request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         done_reg             <= 1'b0;
         idle_reg             <= 1'b0;
         measurement_done_irq <= 1'b0;
      end else begin
         measurement_done_irq <= finish;
         if (finish) begin
            done_reg <= 1'b1;
            idle_reg <= !void_end && !found_busy;
         end else if (req_pulse) begin
            done_reg <= 1'b0;
            idle_reg <= 1'b0;
         end
      end
   end

   // automated energy measurement, once per frame
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ed_active_reg <= 1'b0;
         ed_used_reg   <= 1'b0;
         ed_fin_reg    <= 1'b0;
         ed_cnt_reg    <= '0;
         ed_peak_reg   <= 8'h00;
      end else begin
         if (ed_start) begin
            ed_active_reg <= 1'b1;
            ed_used_reg   <= 1'b1;
            ed_fin_reg    <= 1'b0;
            ed_cnt_reg    <= '0;
            ed_peak_reg   <= radio.energy;
         end else if (ed_active_reg) begin
            ed_cnt_reg <= ed_cnt_reg + CNT_W'(1);
            if (radio.energy > ed_peak_reg)
               ed_peak_reg <= radio.energy;
            if (ed_last) begin
               ed_active_reg <= 1'b0;
               ed_fin_reg    <= 1'b1;
            end
         end
         if (radio.frame_end) begin
            ed_used_reg <= 1'b0;
            ed_fin_reg  <= 1'b0;
         end
      end
   end

   // link quality estimate of the current frame
   lqi_calc #(
      .SHIFT      (3)
   ) u_lqi (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .start      (radio.shr),
      .corr_valid (radio.corr_valid),
      .corr       (radio.corr),
      .frame_end  (radio.frame_end),
      .psdu_len   (radio.psdu_len),
      .lqi_valid  (lqi_valid),
      .lqi        (lqi_val)
   );

   // append link quality byte behind the frame
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fb_wr   <= '0;
         lqi_reg <= LQI_RST;
      end else begin
         fb_wr.we   <= lqi_valid;
         fb_wr.data <= lqi_val;
         if (lqi_valid)
            lqi_reg <= lqi_val;
      end
   end

   // checks on the sequencer, flags, energy measurement, appended byte and bus ack
   a_req_clears_flags: assert property (@(posedge mclk) disable iff (!rst_n)
      req_pulse && !finish |=> !done_reg && !idle_reg)
      else $error("request did not clear flags");

   a_done_with_irq: assert property (@(posedge mclk) disable iff (!rst_n)
      measurement_done_irq |-> done_reg && $past(st_reg) != S_IDLE)
      else $error("interrupt without done flag");

   a_void_request: assert property (@(posedge mclk) disable iff (!rst_n)
      req_pulse && radio.state == RX_OFF ##1 radio.state == RX_OFF && !req_pulse
      |=> measurement_done_irq && done_reg && !idle_reg)
      else $error("request outside receive gave no done");

   a_listen_time: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(done_reg) && $past(st_reg) == S_LISTEN
      |-> $past(cnt_reg) == CNT_W'(RESULT_CYC - 1))
      else $error("listening result not at 140 us");

   a_ed_wait_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      st_reg == S_WAIT && ed_active_reg && !ed_last && !req_pulse
      |=> !measurement_done_irq)
      else $error("result given during energy measurement");

   a_mode2_now: assert property (@(posedge mclk) disable iff (!rst_n)
      st_reg == S_START && !req_pulse && radio.state == RX_BUSY &&
      !header_detect_disable && mode_reg == MODE_CARR |=> measurement_done_irq)
      else $error("mode 2 result not immediate");

   a_ed_once_frame: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(ed_active_reg) |-> !$past(ed_used_reg))
      else $error("second energy measurement in frame");

   a_ed_length: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(ed_active_reg) |-> $past(ed_cnt_reg) == CNT_W'(MEAS_CYC - 1))
      else $error("energy measurement length wrong");

   a_busy_no_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      finish && found_busy |=> done_reg && !idle_reg)
      else $error("busy channel reported idle");

   a_lqi_append: assert property (@(posedge mclk) disable iff (!rst_n)
      radio.frame_end |-> ##2 fb_wr.we)
      else $error("link quality byte not appended");

   a_ack_single: assert property (@(posedge mclk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // main scenarios
   c_listen_done: cover property (@(posedge mclk) disable iff (!rst_n)
      listen_end && !found_busy);
   c_wait_ed: cover property (@(posedge mclk) disable iff (!rst_n)
      st_reg == S_WAIT && busy_end);
   c_void_req: cover property (@(posedge mclk) disable iff (!rst_n)
      void_end);
   c_lqi_frame: cover property (@(posedge mclk) disable iff (!rst_n)
      lqi_valid && lqi_val != 8'h00);
endmodule // cca_lqi_unit
`default_nettype wire

// ### core/cca_pkg.sv
/*
 package for the channel assessment and link quality unit: register map,
 field positions, reset values, timing counts, radio and frame buffer carriers.
 assumes a 10 MHz clock shared with the radio baseband logic.
*/
package cca_pkg;
   // register byte offsets
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] THRES_OFS  = 4'h4;
   localparam logic [3:0] STATUS_OFS = 4'h8;
   localparam logic [3:0] LQI_OFS    = 4'hC;
   // field positions
   localparam int REQ_BIT  = 0;
   localparam int MODE_LSB = 1;
   localparam int HDD_BIT  = 3;
   localparam int DONE_BIT = 0;
   localparam int IDLE_BIT = 1;
   localparam int ST_LSB   = 2;
   localparam int BUSY_BIT = 4;
   localparam int THRES_W  = 4;
   // reset values
   localparam logic [1:0]         MODE_RST  = 2'h1;
   localparam logic [THRES_W-1:0] THRES_RST = 4'h7;
   localparam logic [7:0]         LQI_RST   = 8'h00;
   // timing
   localparam int CLK_MHZ      = 10;
   localparam int RESULT_US    = 140;
   localparam int SYMBOL_US    = 16;
   localparam int MEAS_SYMBOLS = 8;
   localparam int RESULT_CYC   = RESULT_US * CLK_MHZ;
   localparam int MEAS_CYC     = SYMBOL_US * MEAS_SYMBOLS * CLK_MHZ;
   localparam int CNT_W        = 11;
   // link quality
   localparam logic [6:0] MIN_LQI_LEN = 7'h02;
   // assessment modes
   localparam logic [1:0] MODE_OR     = 2'h0;
   localparam logic [1:0] MODE_ENERGY = 2'h1;
   localparam logic [1:0] MODE_CARR   = 2'h2;
   localparam logic [1:0] MODE_AND    = 2'h3;

   typedef enum logic [1:0] {RX_OFF, RX_LISTEN, RX_BUSY} rx_state_e;

   typedef struct packed {
      rx_state_e  state;
      logic       carrier;
      logic [7:0] energy;
      logic       shr;
      logic       frame_end;
      logic       corr_valid;
      logic [7:0] corr;
      logic [6:0] psdu_len;
   } radio_s;

   typedef struct packed {
      logic       we;
      logic [7:0] data;
   } fb_wr_s;
endpackage

// ### core/lqi_calc.sv
/*
 link quality estimator: running average of per symbol correlation values.
 assumes correlation strobes on the same clock, cleared by each sync header.
*/
`timescale 1ns/100ps
`default_nettype none
module lqi_calc
   import cca_pkg::*;
#(
   parameter int SHIFT = 3
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // frame events
   input  wire logic       start,
   input  wire logic       corr_valid,
   input  wire logic [7:0] corr,
   input  wire logic       frame_end,
   input  wire logic [6:0] psdu_len,
   // result
   output logic            lqi_valid,
   output logic [7:0]      lqi
);
   logic [7:0] avg_reg;
   logic [1:0] nsym_reg;
   logic [8:0] diff;
   logic [7:0] avg_next;
   logic       enough;

   // exponential average, stays within 0..255 by construction
   assign diff     = {1'b0, corr} - {1'b0, avg_reg};
   assign avg_next = nsym_reg == 2'h0 ? corr :
                     avg_reg + 8'(signed'(diff) >>> SHIFT);
   assign enough   = psdu_len >= MIN_LQI_LEN && nsym_reg == 2'h2;

   // accumulate over the symbols of one frame
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avg_reg   <= 8'h00;
         nsym_reg  <= 2'h0;
         lqi_valid <= 1'b0;
         lqi       <= LQI_RST;
      end else begin
         lqi_valid <= frame_end;
         if (frame_end)
            lqi <= enough ? avg_reg : 8'h00;
         if (start) begin
            avg_reg  <= 8'h00;
            nsym_reg <= 2'h0;
         end else if (corr_valid) begin
            avg_reg <= avg_next;
            if (nsym_reg != 2'h2)
               nsym_reg <= nsym_reg + 2'h1;
         end
      end
   end
endmodule // lqi_calc
`default_nettype wire

// ### tb/cca_lqi_unit_tb.sv
/*
 self-checking bench for the channel assessment and link quality unit.
 assumes the unit answers classic wishbone one cycle after taking a request.
*/
`timescale 1ns/100ps
`default_nettype none
module cca_lqi_unit_tb
   import cca_pkg::*;
;
   logic        mclk;
   logic        rst_n;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [3:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   radio_s      rad;
   logic        hdd;
   logic        irq;
   fb_wr_s      fbw;
   logic [31:0] q;
   logic [7:0]  lqd;
   int          n;
   int          err_count;
   int          checks_done;
   int          cycles;

   cca_lqi_unit dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .radio(rad), .header_detect_disable(hdd),
      .measurement_done_irq(irq), .fb_wr(fbw));

   // free running 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic give_verdict();
      if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // hang guard, the whole run needs about 5600 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         give_verdict();
      end
   end

   // one classic cycle, entered right after a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      @(posedge mclk);
      while (ack !== 1'b1) begin
         @(posedge mclk);
      end
      chk("ack seen", {31'h0, ack}, 32'h1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge mclk);
   endtask

   // cycles until the done interrupt, counted from the caller's edge, then it must drop
   task automatic wait_irq();
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      @(posedge mclk);
      chk("irq pulse", {31'h0, irq}, 32'h0);
   endtask

   function automatic logic [31:0] st(input logic [1:0] s, input logic idle);
      return {27'h0, 1'b0, s, idle, 1'b1};
   endfunction

   // every mode with both carrier levels, answer expected at once
   task automatic run_modes(input logic e);
      logic b;
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 2; c++) begin
            rad.carrier <= c[0];
            @(posedge mclk);
            bus(1'b1, CTRL_OFS, {28'h0, 1'b0, m[1:0], 1'b1}, 4'hF);
            wait_irq();
            chk("immediate", n, 0);
            b = (m == 0) ? (c[0] | e) : (m == 1) ? e : (m == 2) ? c[0] : (c[0] & e);
            bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
            chk("mode result", q, st(2'h2, !b));
         end
      end
   endtask

   task automatic pulse_shr();
      rad.shr <= 1'b1;
      @(posedge mclk);
      rad.shr <= 1'b0;
   endtask

   // one received frame, then the appended byte two edges after its end
   task automatic frame(input logic [6:0] len, input int syms);
      pulse_shr();
      for (int i = 0; i < syms; i++) begin
         rad.corr_valid <= 1'b1;
         rad.corr <= 8'hC8;
         @(posedge mclk);
         rad.corr_valid <= 1'b0;
         @(posedge mclk);
      end
      rad.psdu_len <= len;
      rad.frame_end <= 1'b1;
      @(posedge mclk);
      rad.frame_end <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("append strobe", {31'h0, fbw.we}, 32'h1);
      lqd = fbw.data;
      @(posedge mclk);
      chk("append single", {31'h0, fbw.we}, 32'h0);
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
      wdat = 32'h0; rad = '0; rad.state = RX_OFF;
      err_count = 0; checks_done = 0; cycles = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      // reset values, unmapped place, masked write
      bus(1'b0, CTRL_OFS, 32'h0, 4'hF);
      chk("ctrl reset", q, 32'h2);
      bus(1'b1, THRES_OFS, 32'h3, 4'h0);
      bus(1'b0, THRES_OFS, 32'h0, 4'hF);
      chk("thres reset", q, 32'h7);
      bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
      chk("status reset", q, 32'h0);
      bus(1'b0, 4'h2, 32'h0, 4'hF);
      chk("unmapped", q, 32'h0);
      // request with the receiver off
      bus(1'b1, CTRL_OFS, 32'h3, 4'hF);
      wait_irq();
      chk("off answer", n, 0);
      bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
      chk("off status", q, st(2'h0, 1'b0));
      // listening, energy at threshold counts as idle
      rad.state <= RX_LISTEN;
      rad.energy <= 8'd14;
      bus(1'b1, CTRL_OFS, 32'h3, 4'hF);
      bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
      chk("flags cleared", q, 32'h14);
      wait_irq();
      chk("listen time", n, RESULT_CYC - 3);
      bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
      chk("idle result", q, st(2'h1, 1'b1));
      // one step over threshold is busy, header detection held off
      rad.energy <= 8'd15;
      bus(1'b1, CTRL_OFS, 32'hB, 4'hF);
      chk("hdd out", {31'h0, hdd}, 32'h1);
      wait_irq();
      chk("hdd time", n, RESULT_CYC);
      bus(1'b0, STATUS_OFS, 32'h0, 4'hF);
      chk("busy result", q, st(2'h1, 1'b0));
      // busy receive, request during the automated measurement waits
      rad.state <= RX_BUSY;
      rad.energy <= 8'd30;
      pulse_shr();
      bus(1'b1, CTRL_OFS, 32'h3, 4'hF);
      chk("hdd off", {31'h0, hdd}, 32'h0);
      wait_irq();
      chk("waits for energy", {31'h0, n > 1260 && n < 1300}, 32'h1);
      run_modes(1'b1);
      // next frame, low energy, carrier only mode never waits
      rad.frame_end <= 1'b1;
      @(posedge mclk);
      rad.frame_end <= 1'b0;
      rad.energy <= 8'd0;
      pulse_shr();
      bus(1'b1, CTRL_OFS, 32'h5, 4'hF);
      wait_irq();
      chk("mode 2 at once", n, 0);
      repeat (1300) @(posedge mclk);
      // a second header in the same frame starts no new measurement
      pulse_shr();
      run_modes(1'b0);
      // link quality byte appended per frame
      frame(7'd20, 16);
      chk("lqi nonzero", {31'h0, lqd !== 8'h00}, 32'h1);
      bus(1'b0, LQI_OFS, 32'h0, 4'hF);
      chk("lqi reg", q, {24'h0, lqd});
      frame(7'd1, 4);
      chk("short frame", {24'h0, lqd}, 32'h0);
      bus(1'b0, LQI_OFS, 32'h0, 4'hF);
      chk("lqi reg short", q, 32'h0);
      give_verdict();
   end
endmodule // cca_lqi_unit_tb
`default_nettype wire
